// file: verilog/ccc_pkg.sv
// Function
// - Count years 2000 through 2099 only.
// - Leap years handled automatically in February.
// - Hours run 00 to 23, no AM/PM.
// - One-second steps, half-second visible to software.
// - All time fields held as BCD.
// - Timekeeping from separate 32.768 kHz crystal clock.
// - Pin drives alarm pulse or seconds clock.
// - Value pointer selects time window pair.
// - High-byte value write while unlocked decrements pointer, floors 00.
// - Alarm pointer selects alarm pair; 11 unmapped.
// - High-byte alarm write decrements pointer, floors 00.
// - Any window read decrements matching pointer.
// - Time writes ignored while unlock bit clear.
// - Unlock set only right after 55h/AAh keys.
// - Run enable writable only while unlocked.
// - Ripple flag warns reads may straddle rollover.
// - Half flag per half; seconds write clears.
// - Output enable connects pin, else undriven.
// - Config register reset only by power-on reset.
// - Drift trim adds/removes 4 pulses per step.
// - Source select: 1 seconds clock, 0 alarm.
// Package of constants and the state record of the calendar core.
// Assumes a single system clock and a power-on reset only.
package ccc_pkg;
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  ADDR_CFG     = 8'h00;
    localparam logic [7:0]  ADDR_VAL     = 8'h04;
    localparam logic [7:0]  ADDR_ALCFG   = 8'h08;
    localparam logic [7:0]  ADDR_ALVAL   = 8'h0C;
    localparam logic [7:0]  ADDR_KEY     = 8'h10;
    localparam logic [7:0]  ADDR_PAD     = 8'h14;
    localparam int          CFG_EN_BIT   = 15;
    localparam int          CFG_UNL_BIT  = 13;
    localparam int          CFG_RIP_BIT  = 12;
    localparam int          CFG_HALF_BIT = 11;
    localparam int          CFG_OE_BIT   = 10;
    localparam int          PTR_LSB      = 8;
    localparam int          PAD_SEL_BIT  = 1;
    localparam logic [15:0] CFG_RESET    = 16'h0000;
    localparam logic [7:0]  KEY_FIRST    = 8'h55;
    localparam logic [7:0]  KEY_SECOND   = 8'hAA;
    localparam int          XTAL_HZ      = 32768;
    localparam int          HALF_DIV     = XTAL_HZ / 2;
    localparam int          TRIM_SHIFT   = 2;
    localparam int          RIPPLE_LEAD  = 32;
    localparam logic signed [15:0] PRESC_LAST = 16'(HALF_DIV - 1);
    localparam logic signed [15:0] PRESC_RIP  =
        16'(HALF_DIV - 1 - RIPPLE_LEAD);
    localparam logic [7:0]  SEC_LAST     = 8'h59;
    localparam logic [7:0]  HOUR_LAST    = 8'h23;
    localparam logic [7:0]  MON_LAST     = 8'h12;
    localparam logic [7:0]  YEAR_LAST    = 8'h99;
    localparam logic [7:0]  BCD_ONE      = 8'h01;
    localparam logic [2:0]  WDAY_LAST    = 3'h6;
    localparam logic [7:0]  DAY_RST      = 8'h01;
    localparam logic [7:0]  MON_RST      = 8'h01;
    localparam logic [2:0]  WDAY_RST     = 3'h6;

    typedef enum logic [1:0] {
        KEY_IDLE      = 2'b00,
        KEY_GOT_FIRST = 2'b01,
        KEY_ARMED     = 2'b10
    } ccc_key_e;

    typedef struct packed {
        logic [2:0]         xtal_sync;
        logic signed [15:0] presc;
        logic               en;
        logic               unlock;
        logic               ripple;
        logic               half;
        logic               oe;
        logic [1:0]         vptr;
        logic [7:0]         trim;
        logic               secsel;
        logic [7:0]         sec;
        logic [7:0]         min;
        logic [7:0]         hour;
        logic [2:0]         wday;
        logic [7:0]         day;
        logic [7:0]         mon;
        logic [7:0]         year;
        logic [5:0]         alcfg_hi;
        logic [1:0]         aptr;
        logic [7:0]         alcfg_lo;
        logic [2:0][15:0]   alrm;
        ccc_key_e           key;
        logic               pready;
        logic               pslverr;
        logic [31:0]        prdata;
        logic               pin;
        logic               pin_oe_n;
    } ccc_state_s;
endpackage : ccc_pkg

// file: verilog/ccc_core.sv
// Calendar core: crystal prescaler, BCD time chain, APB register file.
// Assumes an APB4 master on clk_sys and an asynchronous crystal input.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ccc_core
    import ccc_pkg::*;
(
    // System.
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // APB slave.
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Crystal and alarm.
    input  wire logic              xtal_clk,
    input  wire logic              alarm_pulse,
    // Output pin.
    output logic                   rtc_pin,
    output logic                   rtc_pin_oe_n
);
    ccc_state_s s_reg;
    ccc_state_s s_next;
    logic       setup;
    logic       access;
    logic       tick;
    logic       xtal_edge;

    function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] last,
                                           input logic [7:0] first);
        if (v == last) begin
            return {1'b1, first};
        end else if (v[3:0] == 4'h9) begin
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            return {1'b0, v + 8'h01};
        end
    endfunction : bcd_inc

    // Year 00 stands for 2000, which is a leap year too.
    function automatic logic [7:0] month_last(input logic [7:0] m,
                                              input logic [7:0] y);
        logic [3:0] md;
        md = y[3:0] + {2'h0, y[4], 1'b0};
        if (m == 8'h02) begin
            return (md[1:0] == 2'h0) ? 8'h29 : 8'h28;
        end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 ||
                     m == 8'h11) begin
            return 8'h30;
        end else begin
            return 8'h31;
        end
    endfunction : month_last

    function automatic logic [1:0] ptr_dec(input logic [1:0] p);
        return (p == 2'h0) ? 2'h0 : p - 2'h1;
    endfunction : ptr_dec

    assign setup     = psel & ~penable;
    assign access    = psel & penable & s_reg.pready;
    assign xtal_edge = s_reg.xtal_sync[1] & ~s_reg.xtal_sync[2];

    always_comb begin
        logic [8:0]  r;
        logic        c;
        logic [15:0] vw;
        r  = 9'h0;
        c  = 1'b0;
        vw = 16'h0;
        s_next = s_reg;
        tick   = 1'b0;
        // The crystal is asynchronous, so its first stage feeds only the
        // second one; edges are taken between stages two and three.
        s_next.xtal_sync = {s_reg.xtal_sync[1:0], xtal_clk};
        if (s_reg.en && xtal_edge) begin
            if (s_reg.presc >= PRESC_LAST) begin
                s_next.presc = 16'sh0000;
                tick = 1'b1;
            end else begin
                s_next.presc = s_reg.presc + 16'sh0001;
            end
        end
        if (tick) begin
            s_next.half = ~s_reg.half;
            if (s_reg.half) begin
                r = bcd_inc(s_reg.sec, SEC_LAST, 8'h00);
                s_next.sec = r[7:0];
                c = r[8];
                if (c) begin
                    // Trim is applied once a minute by offsetting the
                    // prescaler, so the next half second is longer or
                    // shorter by four crystal pulses per step.
                    s_next.presc = $signed({{6{s_reg.trim[7]}},
                                            s_reg.trim, 2'b00});
                    r = bcd_inc(s_reg.min, SEC_LAST, 8'h00);
                    s_next.min = r[7:0];
                    c = r[8];
                end
                if (c) begin
                    r = bcd_inc(s_reg.hour, HOUR_LAST, 8'h00);
                    s_next.hour = r[7:0];
                    c = r[8];
                end
                if (c) begin
                    s_next.wday = (s_reg.wday == WDAY_LAST) ? 3'h0
                                : s_reg.wday + 3'h1;
                    r = bcd_inc(s_reg.day,
                                month_last(s_reg.mon, s_reg.year),
                                BCD_ONE);
                    s_next.day = r[7:0];
                    c = r[8];
                end
                if (c) begin
                    r = bcd_inc(s_reg.mon, MON_LAST, BCD_ONE);
                    s_next.mon = r[7:0];
                    c = r[8];
                end
                if (c) begin
                    r = bcd_inc(s_reg.year, YEAR_LAST, 8'h00);
                    s_next.year = r[7:0];
                end
            end
        end
        // Warn readers shortly before the seconds rollover ripples.
        s_next.ripple = s_reg.en & s_reg.half &
                        (s_reg.presc >= PRESC_RIP);

        case (s_reg.vptr)
            2'h0: vw = {s_reg.min, s_reg.sec};
            2'h1: vw = {5'h00, s_reg.wday, s_reg.hour};
            2'h2: vw = {s_reg.mon, s_reg.day};
            default: vw = {8'h00, s_reg.year};
        endcase

        // Zero-wait APB: data is captured in setup, answered in access.
        s_next.pready  = setup;
        s_next.pslverr = 1'b0;
        if (setup) begin
            s_next.prdata = 32'h0;
            if (paddr == ADDR_CFG) begin
                s_next.prdata = {16'h0000, s_reg.en, 1'b0, s_reg.unlock,
                                 s_reg.ripple, s_reg.half, s_reg.oe,
                                 s_reg.vptr, s_reg.trim};
            end else if (paddr == ADDR_VAL) begin
                s_next.prdata = {16'h0000, vw};
            end else if (paddr == ADDR_ALCFG) begin
                s_next.prdata = {16'h0000, s_reg.alcfg_hi, s_reg.aptr,
                                 s_reg.alcfg_lo};
            end else if (paddr == ADDR_ALVAL) begin
                if (s_reg.aptr != 2'h3) begin
                    s_next.prdata = {16'h0000, s_reg.alrm[s_reg.aptr]};
                end
            end else if (paddr == ADDR_PAD) begin
                s_next.prdata = {30'h0, s_reg.secsel, 1'b0};
            end else if (paddr != ADDR_KEY) begin
                s_next.pslverr = 1'b1;
            end
        end

        if (access) begin
            // The key sequence arms for exactly one following transfer.
            if (!(pwrite && paddr == ADDR_KEY)) begin
                s_next.key = KEY_IDLE;
            end
            if (!pwrite && paddr == ADDR_VAL) begin
                s_next.vptr = ptr_dec(s_reg.vptr);
            end else if (!pwrite && paddr == ADDR_ALVAL) begin
                s_next.aptr = ptr_dec(s_reg.aptr);
            end else if (pwrite && paddr == ADDR_CFG) begin
                if (pstrb[0]) begin
                    s_next.trim = pwdata[7:0];
                end
                if (pstrb[1]) begin
                    s_next.vptr = pwdata[PTR_LSB+1:PTR_LSB];
                    s_next.oe   = pwdata[CFG_OE_BIT];
                    if (s_reg.unlock) begin
                        s_next.en = pwdata[CFG_EN_BIT];
                    end
                    s_next.unlock = pwdata[CFG_UNL_BIT] &
                                    (s_reg.unlock |
                                     (s_reg.key == KEY_ARMED));
                end
            end else if (pwrite && paddr == ADDR_VAL && s_reg.unlock) begin
                // Locked writes fall through here untouched.
                if (pstrb[0]) begin
                    case (s_reg.vptr)
                        2'h0: begin
                            s_next.sec   = pwdata[7:0];
                            s_next.half  = 1'b0;
                            s_next.presc = 16'sh0000;
                        end
                        2'h1: s_next.hour = pwdata[7:0];
                        2'h2: s_next.day  = pwdata[7:0];
                        default: s_next.year = pwdata[7:0];
                    endcase
                end
                if (pstrb[1]) begin
                    case (s_reg.vptr)
                        2'h0: s_next.min  = pwdata[15:8];
                        2'h1: s_next.wday = pwdata[10:8];
                        2'h2: s_next.mon  = pwdata[15:8];
                        default: s_next.mon = s_next.mon;
                    endcase
                    s_next.vptr = ptr_dec(s_reg.vptr);
                end
            end else if (pwrite && paddr == ADDR_ALCFG) begin
                if (pstrb[0]) begin
                    s_next.alcfg_lo = pwdata[7:0];
                end
                if (pstrb[1]) begin
                    s_next.aptr     = pwdata[PTR_LSB+1:PTR_LSB];
                    s_next.alcfg_hi = pwdata[15:10];
                end
            end else if (pwrite && paddr == ADDR_ALVAL) begin
                if (s_reg.aptr != 2'h3) begin
                    if (pstrb[0]) begin
                        s_next.alrm[s_reg.aptr][7:0] = pwdata[7:0];
                    end
                    if (pstrb[1]) begin
                        s_next.alrm[s_reg.aptr][15:8] = pwdata[15:8];
                    end
                end
                if (pstrb[1]) begin
                    s_next.aptr = ptr_dec(s_reg.aptr);
                end
            end else if (pwrite && paddr == ADDR_KEY && pstrb[0]) begin
                if (pwdata[7:0] == KEY_FIRST) begin
                    s_next.key = KEY_GOT_FIRST;
                end else if (pwdata[7:0] == KEY_SECOND &&
                             s_reg.key == KEY_GOT_FIRST) begin
                    s_next.key = KEY_ARMED;
                end else begin
                    s_next.key = KEY_IDLE;
                end
            end else if (pwrite && paddr == ADDR_PAD && pstrb[0]) begin
                s_next.secsel = pwdata[PAD_SEL_BIT];
            end
        end

        // The seconds clock is high in the first half of each second.
        s_next.pin = s_reg.secsel ? ~s_reg.half : alarm_pulse;
        s_next.pin_oe_n = ~s_reg.oe;
    end

    // The only reset is power-on, so configuration survives nothing else.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_reg          <= '0;
            s_reg.day      <= DAY_RST;
            s_reg.mon      <= MON_RST;
            s_reg.wday     <= WDAY_RST;
            s_reg.key      <= KEY_IDLE;
            s_reg.pin_oe_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata       = s_reg.prdata;
    assign pready       = s_reg.pready;
    assign pslverr      = s_reg.pslverr;
    assign rtc_pin      = s_reg.pin;
    assign rtc_pin_oe_n = s_reg.pin_oe_n;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    apb_answer_a: assert property (
        setup |=> pready)
        else $error("APB setup not answered next cycle.");
    locked_write_a: assert property (
        (access && pwrite && paddr == ADDR_VAL && !s_reg.unlock && !tick)
        |=> $stable({s_reg.min, s_reg.sec, s_reg.hour, s_reg.year}))
        else $error("Time changed by a locked write.");
    unlock_key_a: assert property (
        $rose(s_reg.unlock) |-> $past(s_reg.key) == KEY_ARMED)
        else $error("Unlock set without key sequence.");
    enable_lock_a: assert property (
        $changed(s_reg.en) |-> $past(s_reg.unlock))
        else $error("Run enable changed while locked.");
    value_ptr_a: assert property (
        (access && !pwrite && paddr == ADDR_VAL)
        |=> s_reg.vptr == ptr_dec($past(s_reg.vptr)))
        else $error("Value pointer did not step on read.");
    alarm_ptr_a: assert property (
        (access && paddr == ADDR_ALVAL && (!pwrite || pstrb[1]))
        |=> s_reg.aptr == ptr_dec($past(s_reg.aptr)))
        else $error("Alarm pointer did not step.");
    half_clear_a: assert property (
        (access && pwrite && paddr == ADDR_VAL && pstrb[0] &&
         s_reg.unlock && s_reg.vptr == 2'h0) |=> !s_reg.half)
        else $error("Half flag not cleared by seconds write.");
    day_wrap_a: assert property (
        (tick && s_reg.half && s_reg.sec == 8'h59 && s_reg.min == 8'h59 &&
         s_reg.hour == 8'h23 && !access) |=> s_reg.hour == 8'h00)
        else $error("Hour did not wrap at midnight.");
    leap_day_a: assert property (
        (tick && s_reg.half && s_reg.sec == 8'h59 && s_reg.min == 8'h59 &&
         s_reg.hour == 8'h23 && s_reg.mon == 8'h02 &&
         s_reg.day == 8'h28 && s_reg.year == 8'h01 && !access)
        |=> s_reg.day == 8'h01 && s_reg.mon == 8'h03)
        else $error("Non-leap February did not end on the 28th.");
endmodule : ccc_core
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the calendar core: APB register tests and pin checks.
// Assumes the core answers APB with its own pready and a free-running crystal.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ccc_pkg::*;

    logic              clk_sys;
    logic              arst_n;
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              xtal_clk;
    logic              alarm_pulse;
    logic              rtc_pin;
    logic              rtc_pin_oe_n;
    logic [31:0]       rdat;
    logic              rerr;
    logic [15:0]       vals [4];
    logic [15:0]       alv  [3];
    int                fail_count;
    int                check_count;

    ccc_core u_ccc_core (
        .clk_sys      (clk_sys),
        .arst_n       (arst_n),
        .paddr        (paddr),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .pwdata       (pwdata),
        .pstrb        (pstrb),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .xtal_clk     (xtal_clk),
        .alarm_pulse  (alarm_pulse),
        .rtc_pin      (rtc_pin),
        .rtc_pin_oe_n (rtc_pin_oe_n)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // The crystal runs free and far too fast, so a whole second fits the
    // run; its edges fall on the falling clock edge, away from sampling.
    initial begin
        xtal_clk = 1'b0;
        forever #4 xtal_clk = ~xtal_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk1

    // The request stands until pready is sampled high at a rising edge;
    // read data and error are taken at that same edge, then released.
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, pready,
                     1'b1);
        end
        rdat    = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        apb(a, 1'b1, {16'h0000, d}, 4'h3);
    endtask : wr

    task automatic key(input logic [7:0] d);
        apb(ADDR_KEY, 1'b1, {24'h000000, d}, 4'h1);
    endtask : key

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        apb(a, 1'b0, 32'h00000000, 4'h0);
        chk(rdat, {16'h0000, e});
        chk1(rerr, 1'b0);
    endtask : rd_chk

    // Both keys and the set must be consecutive transfers.
    task automatic unlock(input logic [15:0] d);
        key(KEY_FIRST);
        key(KEY_SECOND);
        wr(ADDR_CFG, d);
    endtask : unlock

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    initial begin
        // One calendar second at the fast crystal is about 66,000 cycles.
        #320us;
        fail_count++;
        $display("unexpected at %0t: got %h expected %h", $time, 1'b0, 1'b1);
        stop_test();
    end

    initial begin
        fail_count  = 0;
        check_count = 0;
        arst_n      = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = '0;
        pwdata      = 32'h00000000;
        pstrb       = 4'h0;
        alarm_pulse = 1'b0;
        vals = '{16'h0099, 16'h1231, 16'h0623, 16'h5959};
        alv  = '{16'h1225, 16'h0312, 16'h3045};
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd_chk(ADDR_CFG, 16'h0000);
        chk1(rtc_pin_oe_n, 1'b1);
        wr(ADDR_CFG, 16'h8000);
        rd_chk(ADDR_CFG, 16'h0000);
        wr(ADDR_VAL, 16'h1234);
        rd_chk(ADDR_VAL, 16'h0000);
        key(KEY_FIRST);
        key(KEY_SECOND);
        rd_chk(ADDR_CFG, 16'h0000);
        wr(ADDR_CFG, 16'h2000);
        rd_chk(ADDR_CFG, 16'h0000);
        unlock(16'h2300);
        rd_chk(ADDR_CFG, 16'h2300);
        wr(ADDR_VAL, 16'h0099);
        wr(ADDR_VAL, 16'h1231);
        wr(ADDR_VAL, 16'h0623);
        wr(ADDR_VAL, 16'h5958);
        wr(ADDR_VAL, 16'h5959);
        rd_chk(ADDR_CFG, 16'h2000);
        unlock(16'h2300);
        for (int i = 0; i < 4; i++) begin
            rd_chk(ADDR_VAL, vals[i]);
        end
        rd_chk(ADDR_CFG, 16'h2000);
        // Locking again is what software should do after an update.
        wr(ADDR_CFG, 16'h0300);
        rd_chk(ADDR_CFG, 16'h0300);
        wr(ADDR_VAL, 16'h0011);
        rd_chk(ADDR_VAL, 16'h0099);
        rd_chk(ADDR_CFG, 16'h0200);
        wr(ADDR_ALCFG, 16'h0200);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_ALVAL, alv[i]);
        end
        wr(ADDR_ALVAL, 16'h3045);
        rd_chk(ADDR_ALCFG, 16'h0000);
        wr(ADDR_ALCFG, 16'h0300);
        wr(ADDR_ALVAL, 16'h7777);
        rd_chk(ADDR_ALCFG, 16'h0200);
        for (int i = 0; i < 3; i++) begin
            rd_chk(ADDR_ALVAL, alv[i]);
        end
        rd_chk(ADDR_ALCFG, 16'h0000);
        wr(ADDR_ALCFG, 16'h0300);
        rd_chk(ADDR_ALVAL, 16'h0000);
        rd_chk(ADDR_ALCFG, 16'h0200);
        apb(8'h18, 1'b0, 32'h00000000, 4'h0);
        chk1(rerr, 1'b1);
        rd_chk(ADDR_KEY, 16'h0000);
        wr(ADDR_PAD, 16'h0000);
        wr(ADDR_CFG, 16'h0400);
        settle();
        chk1(rtc_pin_oe_n, 1'b0);
        @(posedge clk_sys);
        alarm_pulse <= 1'b1;
        settle();
        chk1(rtc_pin, 1'b1);
        @(posedge clk_sys);
        alarm_pulse <= 1'b0;
        settle();
        chk1(rtc_pin, 1'b0);
        wr(ADDR_PAD, 16'h0002);
        rd_chk(ADDR_PAD, 16'h0002);
        settle();
        chk1(rtc_pin, 1'b1);
        wr(ADDR_CFG, 16'h0000);
        settle();
        chk1(rtc_pin_oe_n, 1'b1);
        // The run bit in the unlocking write itself is still locked out.
        unlock(16'hA300);
        rd_chk(ADDR_CFG, 16'h2300);
        // Load 2001-02-28 23:59:59 so one second crosses a short February.
        wr(ADDR_VAL, 16'h0001);
        wr(ADDR_VAL, 16'h0228);
        wr(ADDR_VAL, 16'h0223);
        wr(ADDR_VAL, 16'h5959);
        wr(ADDR_CFG, 16'hA000);
        rd_chk(ADDR_CFG, 16'hA000);
        // Two cycles per crystal edge: a half second is 32768 cycles.
        repeat (32700) @(posedge clk_sys);
        rd_chk(ADDR_CFG, 16'hA000);
        repeat (100) @(posedge clk_sys);
        rd_chk(ADDR_CFG, 16'hA800);
        repeat (32690) @(posedge clk_sys);
        rd_chk(ADDR_CFG, 16'hB800);
        repeat (100) @(posedge clk_sys);
        wr(ADDR_CFG, 16'hA300);
        rd_chk(ADDR_VAL, 16'h0001);
        rd_chk(ADDR_VAL, 16'h0301);
        rd_chk(ADDR_VAL, 16'h0300);
        rd_chk(ADDR_VAL, 16'h0000);
        rd_chk(ADDR_CFG, 16'hA000);
        stop_test();
    end
endmodule : tb
`default_nettype wire
